/* File: eepw_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
// memory seen from its pins; busy for busy_reads polls after a load
module eepw_dev_model (
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [7:0]  o_dq
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  pg_d [0:63];
  logic [63:0] pg_v = '0;
  logic [47:0] hist = '0;
  logic [7:0]  last = 8'h00;
  logic [6:0]  pg = 7'h00;
  logic        go = 1'b0, prot = 1'b0, tgl = 1'b0, arm_p = 1'b0, arm_u = 1'b0, unl = 1'b0;
  int          reads = 0;
  int          busy_reads = 2;
  wire         wr = !i_ce_n && !i_we_n;
  wire         rd = !i_ce_n && !i_oe_n && i_we_n;
  // erased array at power up
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // byte load: command codes arm a protection change, data fills the page latch
  always @(posedge wr) begin
    #1;
    hist = {hist[39:0], i_dq};
    go = 1'b1;
    reads = 0;
    if (hist[23:0] == 24'hAA55A0) {arm_p, unl} = 2'b11;
    if (hist == 48'hAA5580AA5520) arm_u = 1'b1;
    if (i_addr != 13'h1555 && i_addr != 13'h0AAA && (!prot || unl)) begin
      pg_d[i_addr[5:0]] = i_dq;
      pg_v[i_addr[5:0]] = 1'b1;
      pg = i_addr[12:6];
    end
  end
  // poll read: toggle while busy, commit and settle after busy_reads polls
  always @(posedge rd) begin
    if (go && reads >= busy_reads) begin
      for (int i = 0; i < 64; i++) begin
        if (pg_v[i]) mem[{pg, i[5:0]}] = pg_d[i];
      end
      prot = (prot || arm_p) && !arm_u;
      {go, arm_p, arm_u, unl, pg_v} = '0;
    end else if (go) begin
      tgl = !tgl;
      reads++;
    end
    #1;
    last = o_dq;
  end
  // released bus shows the inverse of the last driven value
  assign o_dq = !rd ? ~last : go ? {mem[i_addr][7], tgl, mem[i_addr][5:0]} : mem[i_addr];
endmodule : eepw_dev_model
`default_nettype wire

/* File: eepw_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: every byte of one page load carries identical page address bits 12..6.
// R2: output strobe held high while write strobe and chip select are low.
// R3: device becomes protected at end of internal write after enable code.
// R4: device becomes unprotected at end of internal write after disable code.
// R5: a protected write loads 1 to 64 bytes after the command code.
// R6: toggle status read by cycling output strobe and chip select repeatedly.
// R7: only a change between successive reads matters, not the level.
// R8: polling address may be anything but stays fixed within one write.
// R9: next byte load starts within 150 us of the previous one.
// R10: device inverts toggle line per read while busy, stable once done.
// R11: device drops unprotected byte loads while protection is active.
module eepw_host #(
  parameter int BLC_CYCLES = eepw_pkg::BLC_CYC,
  parameter int POLL_MAX   = 4_000_000          // gives up on poll POLL_MAX + 1
) (
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_NRST,
  input  wire logic                        I_START,
  input  wire logic [1:0]                  I_OP,
  input  wire logic [eepw_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [eepw_pkg::CNT_W-1:0]  I_COUNT,
  input  wire logic                        I_LOAD,
  input  wire logic [eepw_pkg::DATA_W-1:0] I_LOAD_DATA,
  input  wire logic [eepw_pkg::DATA_W-1:0] I_DQ_IN,
  output logic      [eepw_pkg::ADDR_W-1:0] O_ADDR,
  output logic      [eepw_pkg::DATA_W-1:0] O_DQ_OUT,
  output logic                             O_DQ_OE,
  output logic                             O_CE_N,
  output logic                             O_OE_N,
  output logic                             O_WE_N,
  output logic                             O_BUSY,
  output logic                             O_DONE,
  output logic                             O_TIMEOUT
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HIGH = 3'b011,
    ST_READ = 3'b100,
    ST_RHIGH = 3'b101,
    ST_DONE = 3'b110
  } eepw_state_e;

  typedef struct packed {
    eepw_state_e                 st;
    logic [1:0]                  op;
    logic [eepw_pkg::ADDR_W-1:0] base;
    logic [eepw_pkg::CNT_W-1:0]  cnt;      // data bytes to load
    logic [eepw_pkg::CNT_W-1:0]  idx;      // data byte index
    logic [2:0]                  pre;      // command step index
    logic [eepw_pkg::TMR_W-1:0]  tmr;
    logic [eepw_pkg::CNT_W-1:0]  wptr;
    logic                        first;    // first poll read pending
    logic                        tgl;      // last toggle level
    logic [31:0]                 polls;
    logic [eepw_pkg::ADDR_W-1:0] addr;
    logic [eepw_pkg::DATA_W-1:0] dq;
    logic                        oe_dq;
    logic                        ce_n;
    logic                        oe_n;
    logic                        we_n;
    logic                        done;
    logic                        tout;
    logic                        busy;     // not idle, registered copy of the state test
  } eepw_regs_s;

  eepw_regs_s q, d;
  logic [eepw_pkg::DATA_W-1:0] buf_rd;

  // byte staging buffer, filled by the user before the start
  eepw_page_mem #(
    .DW(eepw_pkg::DATA_W), .DEPTH(eepw_pkg::PAGE_BYTES), .AW(eepw_pkg::PAGE_LSB)
  ) u_buf (
    .I_CLK_SYS(I_CLK_SYS),
    .i_we     (I_LOAD && (q.st == ST_IDLE) && (q.wptr < eepw_pkg::CNT_W'(eepw_pkg::PAGE_BYTES))),
    .i_waddr  (q.wptr[eepw_pkg::PAGE_LSB-1:0]),
    .i_wdata  (I_LOAD_DATA),
    .i_raddr  (d.idx[eepw_pkg::PAGE_LSB-1:0]),
    .o_rdata  (buf_rd)
  );

  // number of command bytes preceding data for an operation
  function automatic logic [2:0] pre_len(input logic [1:0] op);
    case (op)
      eepw_pkg::OP_WRITE:  pre_len = 3'h0;
      eepw_pkg::OP_UNPROT: pre_len = 3'h6;
      default:             pre_len = 3'h3;
    endcase
  endfunction : pre_len

  // address and data of command step k
  function automatic logic [20:0] pre_step(input logic [1:0] op, input logic [2:0] k);
    case (k)
      3'h0, 3'h3: pre_step = {eepw_pkg::UNLK_A0, eepw_pkg::UNLK_D0};
      3'h1, 3'h4: pre_step = {eepw_pkg::UNLK_A1, eepw_pkg::UNLK_D1};
      3'h2:       pre_step = {eepw_pkg::UNLK_A0, (op == eepw_pkg::OP_UNPROT) ?
                              eepw_pkg::CMD_UNPROT2 : eepw_pkg::CMD_PROT};
      default:    pre_step = {eepw_pkg::UNLK_A0, eepw_pkg::CMD_UNPROT};
    endcase
  endfunction : pre_step

  // next state and bus drive
  always_comb begin
    logic [20:0] step;
    logic        more;
    step = pre_step(q.op, q.pre);
    more = 1'b0;
    d = q;
    d.done = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (I_LOAD && q.wptr < eepw_pkg::CNT_W'(eepw_pkg::PAGE_BYTES)) begin
          d.wptr = q.wptr + 1'b1;
        end
        if (I_START) begin
          d.op = I_OP;
          d.base = I_ADDR;
          d.pre = 3'h0;
          d.idx = '0;
          d.tout = 1'b0;
          d.polls = '0;
          // clamp to one page; protect/unprotect carry none
          if (I_OP == eepw_pkg::OP_PROT || I_OP == eepw_pkg::OP_UNPROT) begin
            d.cnt = '0;
          end else if (I_COUNT == '0) begin
            d.cnt = eepw_pkg::CNT_W'(1);                          // see R5
          end else if (I_COUNT > eepw_pkg::CNT_W'(eepw_pkg::PAGE_BYTES)) begin
            d.cnt = eepw_pkg::CNT_W'(eepw_pkg::PAGE_BYTES);       // see R5
          end else begin
            d.cnt = I_COUNT;
          end
          d.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // place address and data with output strobe high
        if (q.pre < pre_len(q.op)) begin
          d.addr = step[20:8];
          d.dq = step[7:0];
        end else begin
          // page bits fixed from the base address, only low bits advance
          d.addr = {q.base[eepw_pkg::ADDR_W-1:eepw_pkg::PAGE_LSB],
                    q.idx[eepw_pkg::PAGE_LSB-1:0] +
                    q.base[eepw_pkg::PAGE_LSB-1:0]};              // see R1
          d.dq = buf_rd;
        end
        d.oe_dq = 1'b1;
        d.oe_n = 1'b1;                                            // see R2
        d.ce_n = 1'b0;
        d.we_n = 1'b0;
        d.tmr = eepw_pkg::TMR_W'(eepw_pkg::WP_CYC - 1);
        d.st = ST_PULSE;
      end
      ST_PULSE: begin
        if (q.tmr == '0) begin
          d.we_n = 1'b1;
          d.ce_n = 1'b1;
          d.tmr = eepw_pkg::TMR_W'(eepw_pkg::WPH_CYC - 1);
          if (q.pre < pre_len(q.op)) begin
            d.pre = q.pre + 1'b1;
            more = (q.pre + 1'b1 < pre_len(q.op)) || (q.cnt != '0);
          end else begin
            d.idx = q.idx + 1'b1;
            more = (q.idx + 1'b1 < q.cnt);
          end
          d.st = more ? ST_HIGH : ST_READ;
          if (!more) begin
            d.oe_dq = 1'b0;
            d.first = 1'b1;
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_HIGH: begin
        // next byte well inside the byte_load_window
        if (q.tmr == '0 || BLC_CYCLES <= eepw_pkg::WPH_CYC) begin
          d.st = ST_SETUP;                                        // see R9
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_READ: begin
        // poll read at the fixed base address
        if (q.ce_n) begin
          d.addr = q.base;                                        // see R8
          d.ce_n = 1'b0;
          d.oe_n = 1'b0;                                          // see R6
          d.tmr = eepw_pkg::TMR_W'(eepw_pkg::RD_CYC - 1);
        end else if (q.tmr == '0) begin
          d.ce_n = 1'b1;
          d.oe_n = 1'b1;
          d.tgl = I_DQ_IN[eepw_pkg::TOGGLE_BIT];
          d.first = 1'b0;
          d.polls = q.polls + 1'b1;
          d.tmr = eepw_pkg::TMR_W'(eepw_pkg::RD_CYC - 1);
          // done when two reads agree; the level itself is ignored
          if (!q.first && I_DQ_IN[eepw_pkg::TOGGLE_BIT] == q.tgl) begin
            d.st = ST_DONE;                                       // see R7, R10
          end else if (q.polls >= 32'(POLL_MAX)) begin
            d.tout = 1'b1;
            d.st = ST_DONE;
          end else begin
            d.st = ST_RHIGH;
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_RHIGH: begin
        // output strobe high pulse between polls
        if (q.tmr == '0) begin
          d.st = ST_READ;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_DONE: begin
        // protection state settled in the device after the write; see R3, R4, R11
        d.done = 1'b1;
        d.wptr = '0;
        d.st = ST_IDLE;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    d.busy = (d.st != ST_IDLE);                                   // busy leaves a flip-flop
  end

  // state register
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      q <= '{st: ST_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign O_ADDR    = q.addr;
  assign O_DQ_OUT  = q.dq;
  assign O_DQ_OE   = q.oe_dq;
  assign O_CE_N    = q.ce_n;
  assign O_OE_N    = q.oe_n;
  assign O_WE_N    = q.we_n;
  assign O_BUSY    = q.busy;
  assign O_DONE    = q.done;
  assign O_TIMEOUT = q.tout;
endmodule : eepw_host
`default_nettype wire

/* File: eepw_host_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// pin discipline of the memory host
module eepw_host_chk (
  input wire logic                        I_CLK_SYS,
  input wire logic                        I_NRST,
  input wire logic [eepw_pkg::ADDR_W-1:0] O_ADDR,
  input wire logic                        O_DQ_OE,
  input wire logic                        O_CE_N,
  input wire logic                        O_OE_N,
  input wire logic                        O_WE_N,
  input wire logic                        O_BUSY,
  input wire logic                        O_DONE
);
  logic [6:0]  pg_q;
  logic [12:0] rd_q;
  logic        wr_q;
  logic        rs_q;
  wire         dat = !O_WE_N && O_ADDR != eepw_pkg::UNLK_A0 && O_ADDR != eepw_pkg::UNLK_A1;
  // last data page and poll address within one operation
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pg_q <= 7'h00;
      rd_q <= 13'h0000;
      wr_q <= 1'b0;
      rs_q <= 1'b0;
    end else begin
      wr_q <= O_BUSY && (wr_q || dat);
      rs_q <= O_BUSY && (rs_q || !O_OE_N);
      if (dat) pg_q <= O_ADDR[12:6];
      if (!O_OE_N) rd_q <= O_ADDR;
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  chk_oe_wr_high: assert property (!O_WE_N && !O_CE_N |-> O_OE_N)
    else $error("output strobe low in write");
  chk_page_same: assert property ($fell(O_WE_N) && dat && wr_q |-> O_ADDR[12:6] == pg_q)
    else $error("page changed in load");
  chk_load_gap: assert property ($rose(O_WE_N) |-> ##[1:40] (!O_WE_N || !O_OE_N))
    else $error("byte load gap too long");
  chk_poll_addr: assert property ($fell(O_OE_N) && rs_q |-> O_ADDR == rd_q)
    else $error("poll address moved");
  chk_rd_hold: assert property ($fell(O_OE_N) |=> (!O_OE_N && !O_CE_N)[*8])
    else $error("poll read too short");
  chk_rd_no_wr: assert property (!O_OE_N |-> O_WE_N && !O_DQ_OE)
    else $error("read overlaps write");
  chk_done_pulse: assert property (O_DONE |-> (O_WE_N && O_OE_N) ##1 !O_DONE)
    else $error("done not a clean pulse");
endmodule : eepw_host_chk
bind eepw_host eepw_host_chk i_chk (.I_CLK_SYS, .I_NRST, .O_ADDR, .O_DQ_OE, .O_CE_N,
  .O_OE_N, .O_WE_N, .O_BUSY, .O_DONE);
`default_nettype wire

/* File: eepw_page_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// small page buffer, read data registered
module eepw_page_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input  wire logic          I_CLK_SYS,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [DEPTH];
  // write port and registered read
  always_ff @(posedge I_CLK_SYS) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : eepw_page_mem
`default_nettype wire

/* File: eepw_pkg.sv */
package eepw_pkg;
  // geometry of the parallel memory
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 8;
  localparam int PAGE_LSB    = 6;            // page address bits are 12..6
  localparam int PAGE_BYTES  = 64;
  localparam int CNT_W       = 7;            // holds 0..64
  localparam int TOGGLE_BIT  = 6;            // toggle status line position
  // clock and bus timing
  localparam int CLK_NS      = 5;
  localparam int WP_NS       = 100;          // least write pulse width
  localparam int WPH_NS      = 50;           // least write pulse high
  localparam int RD_NS       = 150;          // read access, and separately the output enable high pulse
  localparam int BLC_US      = 150;          // byte_load_window, longest
  localparam int WP_CYC      = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC     = (WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC      = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLC_CYC     = (BLC_US * 1000) / CLK_NS;
  localparam int TMR_W       = 16;
  // unlock addresses and codes, values not given here, kept neutral
  localparam logic [12:0] UNLK_A0 = 13'h1555;
  localparam logic [12:0] UNLK_A1 = 13'h0AAA;
  localparam logic [7:0]  UNLK_D0 = 8'hAA;
  localparam logic [7:0]  UNLK_D1 = 8'h55;
  localparam logic [7:0]  CMD_PROT   = 8'hA0;
  localparam logic [7:0]  CMD_UNPROT = 8'h20;
  localparam logic [7:0]  CMD_UNPROT2 = 8'h80;
  // operation codes on the user command port
  localparam logic [1:0] OP_WRITE  = 2'h0;   // plain page write
  localparam logic [1:0] OP_PWRITE = 2'h1;   // protected page write
  localparam logic [1:0] OP_PROT   = 2'h2;   // protection enable only
  localparam logic [1:0] OP_UNPROT = 2'h3;   // protection disable only
endpackage : eepw_pkg

/* File: tb_eepw_host.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_eepw_host;
  logic        clk = 1'b0, nrst = 1'b0, start = 1'b0, load = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [12:0] addr = 13'h0000, a;
  logic [6:0]  cnt = 7'h00;
  logic [7:0]  ld = 8'h00, dqo, mdq;
  logic        dq_oe, ce_n, oe_n, we_n, busy, done, tmo;
  wire  [7:0]  dq = dq_oe ? dqo : mdq;
  int          errors = 0, n_compared = 0, dones = 0;
  // 200 MHz clock and completion pulse count
  always #2.5 clk = ~clk;
  always @(negedge clk) if (done === 1'b1) dones++;
  eepw_host #(.POLL_MAX(50)) i_dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_START(start),
    .I_OP(op), .I_ADDR(addr), .I_COUNT(cnt), .I_LOAD(load), .I_LOAD_DATA(ld), .I_DQ_IN(dq),
    .O_ADDR(a), .O_DQ_OUT(dqo), .O_DQ_OE(dq_oe), .O_CE_N(ce_n), .O_OE_N(oe_n),
    .O_WE_N(we_n), .O_BUSY(busy), .O_DONE(done), .O_TIMEOUT(tmo));
  eepw_dev_model i_mdl (.i_addr(a), .i_dq(dq), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .o_dq(mdq));
  task automatic summarize();
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // stage n bytes, start, wait for idle, judge timeout flag and done pulse
  task automatic run(input logic [1:0] o, input logic [12:0] ad, input int n,
                     input logic [7:0] b0, input logic to);
    int i;
    int d0;
    d0 = dones;
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      load = 1'b1;
      ld = b0 + 8'(i);
    end
    @(negedge clk);
    load = 1'b0;
    {op, addr, cnt} = {o, ad, 7'(n)};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 9000 && busy !== 1'b0; i++) @(negedge clk);
    if (i == 9000) begin
      errors++;
      summarize();
    end
    // let the pulse counter settle before judging it
    @(negedge clk);
    check({7'h00, tmo}, {7'h00, to});
    check(8'(dones - d0), 8'h01);
  endtask : run
  // three bytes from offset 62 wrap inside one page
  task automatic s_plain();
    i_mdl.busy_reads = 2;
    run(eepw_pkg::OP_WRITE, 13'h0ABE, 3, 8'h10, 1'b0);
    check(i_mdl.mem[13'h0ABE], 8'h10);
    check(i_mdl.mem[13'h0ABF], 8'h11);
    check(i_mdl.mem[13'h0A80], 8'h12);
  endtask : s_plain
  // protect alone, refused plain write, full protected page, unprotect, slow device
  task automatic s_protect();
    i_mdl.busy_reads = 20;
    run(eepw_pkg::OP_PROT, 13'h0000, 0, 8'h00, 1'b0);
    check({7'h00, i_mdl.prot}, 8'h01);
    run(eepw_pkg::OP_WRITE, 13'h0100, 1, 8'h33, 1'b0);
    check(i_mdl.mem[13'h0100], 8'hFF);
    run(eepw_pkg::OP_PWRITE, 13'h0140, 64, 8'h40, 1'b0);
    check(i_mdl.mem[13'h0140], 8'h40);
    check(i_mdl.mem[13'h017F], 8'h7F);
    run(eepw_pkg::OP_UNPROT, 13'h0000, 0, 8'h00, 1'b0);
    check({7'h00, i_mdl.prot}, 8'h00);
    run(eepw_pkg::OP_WRITE, 13'h0100, 1, 8'h33, 1'b0);
    check(i_mdl.mem[13'h0100], 8'h33);
  endtask : s_protect
  // device that never settles: polling gives up and flags it
  task automatic s_timeout();
    i_mdl.busy_reads = 1000;
    run(eepw_pkg::OP_WRITE, 13'h0200, 1, 8'h77, 1'b1);
    check(i_mdl.mem[13'h0200], 8'hFF);
  endtask : s_timeout
  // reset, scenarios, verdict
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    s_plain();
    s_protect();
    s_timeout();
    summarize();
  end
endmodule : tb_eepw_host
`default_nettype wire
